// ===== src/slave_port_pkg.sv
// constants for the parallel slave port block
`default_nettype none
package slave_port_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 32;
    localparam int          PORT_W          = 8;
    localparam int          CTRL_W          = 3;
    localparam int          IRQ_W           = 3;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL_STATUS = 8'h00;
    localparam logic [7:0]  OFS_DATA_PORT   = 8'h04;
    localparam logic [7:0]  OFS_DATA_DIR    = 8'h08;
    localparam logic [7:0]  OFS_CTRL_DIR    = 8'h0c;
    localparam logic [7:0]  OFS_ANALOG_CFG  = 8'h10;
    localparam logic [7:0]  OFS_CTRL_PORT   = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h18;
    localparam logic [7:0]  OFS_IRQ_ENABLE  = 8'h1c;
    localparam logic [7:0]  OFS_IRQ_CLEAR   = 8'h20;

    // control/status field positions
    localparam int          BIT_IN_FULL     = 7;
    localparam int          BIT_OUT_FULL    = 6;
    localparam int          BIT_OVERRUN     = 5;
    localparam int          BIT_PORT_SEL    = 4;

    // control pin order
    localparam int          PIN_READ        = 0;
    localparam int          PIN_WRITE       = 1;
    localparam int          PIN_SELECT      = 2;

    // interrupt status bits
    localparam int          IRQ_HOST_WRITE  = 0;
    localparam int          IRQ_HOST_READ   = 1;
    localparam int          IRQ_OVERRUN     = 2;

    // reset values and the all-digital analog config value
    localparam logic [7:0]  RST_DATA_DIR    = 8'hff;
    localparam logic [2:0]  RST_CTRL_DIR    = 3'h7;
    localparam logic [2:0]  RST_ANALOG_CFG  = 3'h0;
    localparam logic [2:0]  CFG_ALL_DIGITAL = 3'h7;
endpackage
`default_nettype wire

// ===== src/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_val_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    initial begin
        if (WIDTH < 1) begin
            $error("pin_sync: WIDTH must be at least 1");
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            meta     <= reset_val_in;
            sync_out <= reset_val_in;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end
endmodule
`default_nettype wire

// ===== src/irq_block.sv
// sticky event status, enable mask and level interrupt
`default_nettype none
module irq_block #(
    parameter int WIDTH = 3
) (
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] event_in,
    input  wire logic             enable_we_in,
    input  wire logic             clear_we_in,
    input  wire logic [WIDTH-1:0] wdata_in,
    output logic      [WIDTH-1:0] status_out,
    output logic      [WIDTH-1:0] enable_out,
    output logic                  irq_out
);
    initial begin
        if (WIDTH < 1) begin
            $error("irq_block: WIDTH must be at least 1");
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            // a new event beats a clear in the same cycle
            always_ff @(posedge core_clk_in) begin
                if (!rst_n_in) begin
                    status_out[i] <= 1'b0;
                end else if (event_in[i]) begin
                    status_out[i] <= 1'b1;
                end else if (clear_we_in && wdata_in[i]) begin
                    status_out[i] <= 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            enable_out <= '0;
        end else if (enable_we_in) begin
            enable_out <= wdata_in;
        end
    end

    assign irq_out = |(status_out & enable_out);
endmodule
`default_nettype wire

// ===== src/parallel_slave_port.sv
// parallel slave port with general data port, control port and apb registers
//
// Summary of operation
// - With the port select bit set the data port works as a host latch, else as plain gpio.
// - In slave port mode the three low control pins are the host read, write and select inputs.
// - A host write happens when select and write strobe are first seen low together.
// - A host read happens when select and read strobe are first seen low, and drives the byte.
// - In slave port mode the control inputs use ttl buffers instead of schmitt triggers.
// - Input buffer full in bit 7 is set by a received host word and is 0 when none waits.
// - Output buffer full in bit 6 stays set until the host has read the written word.
`default_nettype none
module parallel_slave_port
    import slave_port_pkg::*;
(
    input  wire logic                               core_clk_in,
    input  wire logic                               rst_n_in,
    // apb slave
    input  wire logic                               psel_in,
    input  wire logic                               penable_in,
    input  wire logic                               pwrite_in,
    input  wire logic [slave_port_pkg::ADDR_W-1:0]  paddr_in,
    input  wire logic [slave_port_pkg::DATA_W-1:0]  pwdata_in,
    output logic      [slave_port_pkg::DATA_W-1:0]  prdata_out,
    output logic                                    pready_out,
    output logic                                    pslverr_out,
    // data port pins
    input  wire logic [slave_port_pkg::PORT_W-1:0]  data_pin_in,
    output logic      [slave_port_pkg::PORT_W-1:0]  data_pin_out,
    output logic      [slave_port_pkg::PORT_W-1:0]  data_pin_oe_n_out,
    // control port pins: read strobe, write strobe, select
    input  wire logic [slave_port_pkg::CTRL_W-1:0]  ctrl_pin_in,
    output logic      [slave_port_pkg::CTRL_W-1:0]  ctrl_pin_out,
    output logic      [slave_port_pkg::CTRL_W-1:0]  ctrl_pin_oe_n_out,
    output logic                                    ctrl_ttl_buf_out,
    output logic                                    irq_out
);
    import slave_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // state
    logic                 slave_port_select;
    logic                 in_buf_full;
    logic                 out_buf_full;
    logic                 in_overrun;
    logic [PORT_W-1:0]    in_latch;
    logic [PORT_W-1:0]    out_latch;
    logic [PORT_W-1:0]    data_dir;
    logic [CTRL_W-1:0]    control_pin_direction;
    logic [CTRL_W-1:0]    analog_pin_config;
    logic [CTRL_W-1:0]    control_port;
    logic [PORT_W-1:0]    data_sync;
    logic [CTRL_W-1:0]    ctrl_sync;
    logic                 write_seen;
    logic                 read_seen;
    logic [IRQ_W-1:0]     irq_status;
    logic [IRQ_W-1:0]     irq_enable;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    pin_sync #(.WIDTH(PORT_W)) u_data_sync (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .async_in     (data_pin_in),
        .reset_val_in ('0),
        .sync_out     (data_sync)
    );

    pin_sync #(.WIDTH(CTRL_W)) u_ctrl_sync (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .async_in     (ctrl_pin_in),
        // strobes idle high, so no false edge follows reset
        .reset_val_in ('1),
        .sync_out     (ctrl_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // host strobe decode
    logic                 select_low;
    logic                 write_low;
    logic                 read_low;
    logic                 host_write;
    logic                 host_read;
    logic                 ctrl_digital;

    // strobes count only after a high was seen in slave mode
    assign ctrl_digital = (analog_pin_config == CFG_ALL_DIGITAL);
    assign select_low   = slave_port_select && !ctrl_sync[PIN_SELECT];
    assign write_low    = select_low && !ctrl_sync[PIN_WRITE];
    assign read_low     = select_low && !ctrl_sync[PIN_READ];
    assign host_write   = write_low && !write_seen;
    assign host_read    = read_low && !read_seen;

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            write_seen <= 1'b1;
            read_seen  <= 1'b1;
        end else begin
            write_seen <= write_low || (!slave_port_select && write_seen);
            read_seen  <= read_low || (!slave_port_select && read_seen);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode
    logic                 setup;
    logic                 access;
    logic                 wr_en;
    logic                 rd_en;
    logic                 addr_ok;
    logic                 cpu_data_wr;
    logic                 cpu_data_rd;
    logic                 cpu_ctrl_wr;
    logic [DATA_W-1:0]    next_rdata;

    assign setup       = psel_in && !penable_in;
    assign access      = psel_in && penable_in;
    assign wr_en       = access && pwrite_in;
    assign rd_en       = access && !pwrite_in;
    assign pready_out  = 1'b1;
    assign cpu_data_wr = wr_en && (paddr_in == OFS_DATA_PORT);
    assign cpu_data_rd = rd_en && (paddr_in == OFS_DATA_PORT);
    assign cpu_ctrl_wr = wr_en && (paddr_in == OFS_CTRL_STATUS);

    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr_in)
            OFS_CTRL_STATUS, OFS_DATA_PORT, OFS_DATA_DIR, OFS_CTRL_DIR,
            OFS_ANALOG_CFG, OFS_CTRL_PORT, OFS_IRQ_STATUS, OFS_IRQ_ENABLE,
            OFS_IRQ_CLEAR: addr_ok = 1'b1;
            default: addr_ok = 1'b0;
        endcase
    end

    assign pslverr_out = access && !addr_ok;

    always_comb begin
        next_rdata = '0;
        unique case (paddr_in)
            OFS_CTRL_STATUS: begin
                next_rdata[BIT_IN_FULL]  = in_buf_full;
                next_rdata[BIT_OUT_FULL] = out_buf_full;
                next_rdata[BIT_OVERRUN]  = in_overrun;
                next_rdata[BIT_PORT_SEL] = slave_port_select;
            end
            // slave mode returns the host byte, gpio mode the pins
            OFS_DATA_PORT:  next_rdata[PORT_W-1:0] = slave_port_select ? in_latch : data_sync;
            OFS_DATA_DIR:   next_rdata[PORT_W-1:0] = data_dir;
            OFS_CTRL_DIR:   next_rdata[CTRL_W-1:0] = control_pin_direction;
            OFS_ANALOG_CFG: next_rdata[CTRL_W-1:0] = analog_pin_config;
            // all pins read as zero unless all three are configured digital
            OFS_CTRL_PORT:  next_rdata[CTRL_W-1:0] = ctrl_digital ? ctrl_sync : '0;
            OFS_IRQ_STATUS: next_rdata[IRQ_W-1:0]  = irq_status;
            OFS_IRQ_ENABLE: next_rdata[IRQ_W-1:0]  = irq_enable;
            default:        next_rdata = '0;
        endcase
    end

    // read data captured in the setup cycle, held through the access cycle
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            prdata_out <= '0;
        end else if (setup && !pwrite_in) begin
            prdata_out <= next_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // configuration registers
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            slave_port_select <= 1'b0;
        end else if (cpu_ctrl_wr) begin
            slave_port_select <= pwdata_in[BIT_PORT_SEL];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            data_dir              <= RST_DATA_DIR;
            control_pin_direction <= RST_CTRL_DIR;
            analog_pin_config     <= RST_ANALOG_CFG;
            control_port          <= '0;
        end else if (wr_en) begin
            if (paddr_in == OFS_DATA_DIR) begin
                data_dir <= pwdata_in[PORT_W-1:0];
            end
            if (paddr_in == OFS_CTRL_DIR) begin
                control_pin_direction <= pwdata_in[CTRL_W-1:0];
            end
            if (paddr_in == OFS_ANALOG_CFG) begin
                analog_pin_config <= pwdata_in[CTRL_W-1:0];
            end
            if (paddr_in == OFS_CTRL_PORT) begin
                control_port <= pwdata_in[CTRL_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // byte latches and buffer flags
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            in_latch <= '0;
        end else if (host_write && !in_buf_full) begin
            // a write onto an unread word is dropped, the old word kept
            in_latch <= data_sync;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            in_buf_full <= 1'b0;
        end else if (host_write) begin
            in_buf_full <= 1'b1;
        end else if (cpu_data_rd && slave_port_select) begin
            in_buf_full <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            in_overrun <= 1'b0;
        end else if (host_write && in_buf_full) begin
            in_overrun <= 1'b1;
        end else if (cpu_ctrl_wr && !pwdata_in[BIT_OVERRUN]) begin
            in_overrun <= 1'b0;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            out_latch <= '0;
        end else if (cpu_data_wr) begin
            out_latch <= pwdata_in[PORT_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            out_buf_full <= 1'b0;
        end else if (cpu_data_wr && slave_port_select) begin
            out_buf_full <= 1'b1;
        end else if (host_read) begin
            out_buf_full <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drivers
    always_ff @(posedge core_clk_in) begin
        if (!rst_n_in) begin
            data_pin_out      <= '0;
            data_pin_oe_n_out <= '1;
            ctrl_pin_out      <= '0;
            ctrl_pin_oe_n_out <= '1;
            ctrl_ttl_buf_out  <= 1'b0;
        end else begin
            data_pin_out      <= out_latch;
            // slave mode drives only while a host read lasts
            data_pin_oe_n_out <= slave_port_select ? {PORT_W{!read_low}} : data_dir;
            ctrl_pin_out      <= control_port;
            ctrl_pin_oe_n_out <= control_pin_direction;
            ctrl_ttl_buf_out  <= slave_port_select;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts
    logic [IRQ_W-1:0]     irq_events;

    assign irq_events[IRQ_HOST_WRITE] = host_write;
    assign irq_events[IRQ_HOST_READ]  = host_read;
    assign irq_events[IRQ_OVERRUN]    = host_write && in_buf_full;

    irq_block #(.WIDTH(IRQ_W)) u_irq (
        .core_clk_in  (core_clk_in),
        .rst_n_in     (rst_n_in),
        .event_in     (irq_events),
        .enable_we_in (wr_en && (paddr_in == OFS_IRQ_ENABLE)),
        .clear_we_in  (wr_en && (paddr_in == OFS_IRQ_CLEAR)),
        .wdata_in     (pwdata_in[IRQ_W-1:0]),
        .status_out   (irq_status),
        .enable_out   (irq_enable),
        .irq_out      (irq_out)
    );

    logic unused_bits;
    assign unused_bits = ^{pwdata_in[DATA_W-1:PORT_W], rd_en};
endmodule
`default_nettype wire

// ===== src/unused_placeholder_none.sv
// intentionally empty
`default_nettype none
`default_nettype wire

// ===== sim/slave_port_checker.sv
// concurrent assertions on the parallel slave port top ports
`default_nettype none
module slave_port_checker
    import slave_port_pkg::*;
(
    input wire logic        core_clk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [7:0]  paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [7:0]  data_pin_in,
    input wire logic [7:0]  data_pin_out,
    input wire logic [7:0]  data_pin_oe_n_out,
    input wire logic [2:0]  ctrl_pin_in,
    input wire logic [2:0]  ctrl_pin_out,
    input wire logic [2:0]  ctrl_pin_oe_n_out,
    input wire logic        ctrl_ttl_buf_out,
    input wire logic        irq_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);

    logic acc;
    logic mapped;
    assign acc = psel_in && penable_in;
    assign mapped = (paddr_in[1:0] == 2'h0) && (paddr_in <= OFS_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////////////////
    a_ready_in_access: assert property (acc |-> pready_out)
        else $error("ready low in access phase");
    a_err_unmapped: assert property (acc && !mapped |-> pslverr_out)
        else $error("no error on unmapped address");
    a_no_err_mapped: assert property (acc && mapped |-> !pslverr_out)
        else $error("error on mapped address");
    a_err_read_zero: assert property (
        acc && pslverr_out && !pwrite_in |-> prdata_out == 32'h0)
        else $error("refused read returned data");
    a_ttl_follows_mode: assert property (
        acc && pwrite_in && paddr_in == OFS_CTRL_STATUS
        |-> ##2 ctrl_ttl_buf_out == $past(pwdata_in[BIT_PORT_SEL], 2))
        else $error("buffer type does not follow mode");
    a_ctrl_dir_oe: assert property (
        acc && pwrite_in && paddr_in == OFS_CTRL_DIR
        |-> ##2 ctrl_pin_oe_n_out == $past(pwdata_in[2:0], 2))
        else $error("control pin direction not applied");
    a_data_latch_out: assert property (
        acc && pwrite_in && paddr_in == OFS_DATA_PORT
        |-> ##2 data_pin_out == $past(pwdata_in[7:0], 2))
        else $error("data latch not on pins");
    a_irq_masked: assert property (
        acc && pwrite_in && paddr_in == OFS_IRQ_ENABLE
        && pwdata_in[2:0] == 3'h0 |=> !irq_out)
        else $error("interrupt with all enables off");
    a_drive_whole_byte: assert property (
        ctrl_ttl_buf_out && $past(ctrl_ttl_buf_out)
        |-> data_pin_oe_n_out == 8'h00 || data_pin_oe_n_out == 8'hff)
        else $error("partial byte drive in slave mode");
    a_drive_needs_read: assert property (
        ctrl_ttl_buf_out && data_pin_oe_n_out != 8'hff
        |-> (!$past(ctrl_pin_in[PIN_READ], 3) && !$past(ctrl_pin_in[PIN_SELECT], 3))
        || (!$past(ctrl_pin_in[PIN_READ], 4) && !$past(ctrl_pin_in[PIN_SELECT], 4)))
        else $error("data driven without host read");
    a_read_drives: assert property (
        ctrl_ttl_buf_out
        && !$past(ctrl_pin_in[PIN_READ], 3) && !$past(ctrl_pin_in[PIN_SELECT], 3)
        && !$past(ctrl_pin_in[PIN_READ], 4) && !$past(ctrl_pin_in[PIN_SELECT], 4)
        |-> data_pin_oe_n_out == 8'h00)
        else $error("host read not driven");
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n_in
        |=> !irq_out && data_pin_oe_n_out == 8'hff && !ctrl_ttl_buf_out)
        else $error("outputs active after reset");

    c_host_read: cover property (ctrl_ttl_buf_out && data_pin_oe_n_out == 8'h00);
    c_refused: cover property (acc && pslverr_out);
    c_irq: cover property ($rose(irq_out));
endmodule
`default_nettype wire

// ===== sim/host_cpu_model.sv
// behavioural host processor on the slave port strobes and data lines
`default_nettype none
module host_cpu_model (
    input  wire logic       clk_in,
    input  wire logic [7:0] bus_in,
    output logic      [2:0] strobe_n_out,
    output logic      [7:0] data_out
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int HOLD = 6;

    initial begin
        strobe_n_out = 3'h7;
        data_out = 8'h00;
    end

    // released data lines show the inverse of the last byte
    task automatic write_byte(input logic [7:0] b);
        @(posedge clk_in);
        data_out <= b;
        strobe_n_out <= 3'b001;
        repeat (HOLD) @(posedge clk_in);
        strobe_n_out <= 3'b111;
        data_out <= ~b;
        repeat (HOLD) @(posedge clk_in);
    endtask

    task automatic read_byte(output logic [7:0] b);
        @(posedge clk_in);
        strobe_n_out <= 3'b010;
        repeat (HOLD) @(posedge clk_in);
        b = bus_in;
        strobe_n_out <= 3'b111;
        repeat (HOLD) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// testbench: apb register sequences against a host processor model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import slave_port_pkg::*;

    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [7:0]  dpin_in;
    logic [7:0]  dpin_out;
    logic [7:0]  doe_n;
    logic [2:0]  cpin_in;
    logic [2:0]  cpin_out;
    logic [2:0]  coe_n;
    logic        ttl;
    logic        irq;
    logic [2:0]  host_strobe_n;
    logic [7:0]  host_data;
    int          bad_count = 0;
    int          comparisons = 0;

    always #12.5 clk = ~clk;
    assign dpin_in = (~doe_n & dpin_out) | (doe_n & host_data);
    assign cpin_in = (~coe_n & cpin_out) | (coe_n & host_strobe_n);

    parallel_slave_port dut (
        .core_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .data_pin_in(dpin_in),
        .data_pin_out(dpin_out), .data_pin_oe_n_out(doe_n), .ctrl_pin_in(cpin_in),
        .ctrl_pin_out(cpin_out), .ctrl_pin_oe_n_out(coe_n), .ctrl_ttl_buf_out(ttl),
        .irq_out(irq));
    host_cpu_model host (.clk_in(clk), .bus_in(dpin_in), .strobe_n_out(host_strobe_n),
        .data_out(host_data));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic err);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        // only the watchdog ends a wait that never gets an answer
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3000) @(posedge clk);
        bad_count++;
        wrap_up();
    end

    initial begin
        logic [31:0] q;
        logic        e;
        logic [7:0]  b;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CTRL_STATUS, 32'h0);
        rd(OFS_DATA_DIR, 32'hff);
        rd(OFS_CTRL_DIR, 32'h7);
        rd(OFS_ANALOG_CFG, 32'h0);
        rd(OFS_IRQ_ENABLE, 32'h0);
        apb(1'b0, 8'h24, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        // plain port mode
        wr(OFS_DATA_DIR, 32'h0);
        wr(OFS_DATA_PORT, 32'ha5);
        repeat (3) @(posedge clk);
        chk({24'h0, dpin_out}, 32'ha5);
        chk({24'h0, doe_n}, 32'h0);
        rd(OFS_DATA_PORT, 32'ha5);
        wr(OFS_CTRL_PORT, 32'h5);
        repeat (2) @(posedge clk);
        chk({29'h0, cpin_out}, 32'h5);
        wr(OFS_DATA_DIR, 32'hff);
        host.write_byte(8'h66);
        rd(OFS_CTRL_STATUS, 32'h0);
        // slave port setup
        wr(OFS_CTRL_DIR, 32'h7);
        wr(OFS_ANALOG_CFG, {29'h0, CFG_ALL_DIGITAL});
        rd(OFS_CTRL_PORT, 32'h7);
        wr(OFS_IRQ_ENABLE, 32'h7);
        wr(OFS_CTRL_STATUS, 32'hff);
        rd(OFS_CTRL_STATUS, 32'h10);
        chk({31'h0, ttl}, 32'h1);
        // host writes, second one onto an unread word
        host.write_byte(8'h3c);
        rd(OFS_CTRL_STATUS, 32'h90);
        chk({31'h0, irq}, 32'h1);
        rd(OFS_IRQ_STATUS, 32'h1);
        host.write_byte(8'hc3);
        rd(OFS_CTRL_STATUS, 32'hb0);
        rd(OFS_IRQ_STATUS, 32'h5);
        rd(OFS_DATA_PORT, 32'h3c);
        rd(OFS_CTRL_STATUS, 32'h30);
        wr(OFS_CTRL_STATUS, 32'h30);
        rd(OFS_CTRL_STATUS, 32'h30);
        wr(OFS_CTRL_STATUS, 32'h10);
        rd(OFS_CTRL_STATUS, 32'h10);
        // cpu byte read by the host
        wr(OFS_DATA_PORT, 32'h5a);
        rd(OFS_CTRL_STATUS, 32'h50);
        host.read_byte(b);
        chk({24'h0, b}, 32'h5a);
        rd(OFS_CTRL_STATUS, 32'h10);
        rd(OFS_IRQ_STATUS, 32'h7);
        wr(OFS_IRQ_CLEAR, 32'h7);
        rd(OFS_IRQ_CLEAR, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        // masked event
        wr(OFS_IRQ_ENABLE, 32'h2);
        host.write_byte(8'h11);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_IRQ_STATUS, 32'h1);
        rd(OFS_DATA_PORT, 32'h11);
        wr(OFS_IRQ_ENABLE, 32'h0);
        wr(OFS_CTRL_STATUS, 32'h0);
        repeat (2) @(posedge clk);
        chk({31'h0, ttl}, 32'h0);
        wrap_up();
    end
endmodule

bind parallel_slave_port slave_port_checker chk_i (
    .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .data_pin_in(data_pin_in), .data_pin_out(data_pin_out),
    .data_pin_oe_n_out(data_pin_oe_n_out), .ctrl_pin_in(ctrl_pin_in),
    .ctrl_pin_out(ctrl_pin_out), .ctrl_pin_oe_n_out(ctrl_pin_oe_n_out),
    .ctrl_ttl_buf_out(ctrl_ttl_buf_out), .irq_out(irq_out));
`default_nettype wire
